// File: rtl/sft_pkg.sv
// Shared constants and types for the sample filter and range addressing core.
// Assumes a single 20 MHz clock and an AXI4-Lite register port with 8-bit addresses.
package sft_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ           = 20_000_000;
	localparam int unsigned SAMPLE_PERIOD_MS = 20;
	localparam int unsigned SAMPLE_CYC       = CLK_HZ / 1000 * SAMPLE_PERIOD_MS;
	localparam int unsigned UART_BAUD        = 9600;
	localparam logic [15:0] BAUD_DIV_RST     = 16'(CLK_HZ / UART_BAUD);

	// ------------------------------------------------------------
	// Datapath widths and filter constants
	// ------------------------------------------------------------
	localparam int unsigned RAW_W      = 24;
	localparam int unsigned WEIGHT_W   = 7;
	localparam logic [6:0]  WEIGHT_RST = 7'h5A;
	localparam logic [6:0]  WEIGHT_MAX = 7'h63;
	localparam logic [6:0]  PCT_FULL   = 7'h64;
	// A step is large when step * 5000 exceeds full scale, i.e. above 0.02 %.
	localparam logic [12:0] STEP_DIV   = 13'h1388;
	localparam logic [23:0] FSCALE_RST = 24'hFFFFFF;

	// ------------------------------------------------------------
	// Characters
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_RST    = 8'h31;
	localparam logic [7:0] CH_WILD     = 8'h2A;
	localparam logic [7:0] CH_START    = 8'h23;
	localparam logic [7:0] CH_CR       = 8'h0D;
	localparam logic [7:0] CH_LF       = 8'h0A;
	localparam logic [7:0] CH_QUERY    = 8'h3F;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_WEIGHT0 = 8'h04;
	localparam logic [7:0] OFS_WEIGHT1 = 8'h08;
	localparam logic [7:0] OFS_ADDR0   = 8'h0C;
	localparam logic [7:0] OFS_ADDR1   = 8'h10;
	localparam logic [7:0] OFS_FSCALE0 = 8'h14;
	localparam logic [7:0] OFS_FSCALE1 = 8'h18;
	localparam logic [7:0] OFS_BAUD    = 8'h1C;
	localparam logic [7:0] OFS_PRESS   = 8'h20;
	localparam logic [7:0] OFS_RAW     = 8'h24;
	localparam logic [7:0] OFS_STATUS  = 8'h28;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0]  addr;
		logic [6:0]  weight;
		logic [23:0] fscale;
	} sft_range_cfg_t;

	typedef struct packed {
		logic [7:0] cmd;
		logic       query;
	} sft_frame_t;

	typedef enum logic [1:0] {
		PS_IDLE = 2'b00,
		PS_ADDR = 2'b01,
		PS_BODY = 2'b10,
		PS_SKIP = 2'b11
	} sft_parse_t;

	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_DATA  = 2'b10,
		RX_STOP  = 2'b11
	} sft_rx_t;

endpackage

// File: rtl/sft_filter.sv
// Exponential smoothing filter with step bypass for one sample stream.
// Assumes one strobe per sample period and weight already limited to 0..99.
`timescale 1ns/1ps
module sft_filter (
	// Clock and reset
	input  wire logic                      clk_i,
	input  wire logic                      sys_rst_i,
	// Sample in and settings of the active range
	input  wire logic                      sample_stb_i,
	input  wire logic [sft_pkg::RAW_W-1:0] raw_i,
	input  wire logic [6:0]                weight_i,
	input  wire logic [23:0]               fscale_i,
	// Filtered result
	output logic      [sft_pkg::RAW_W-1:0] filt_o,
	output logic                           bypass_o,
	output logic                           primed_o
);
	import sft_pkg::*;

	logic [RAW_W-1:0] prev_raw;
	logic [RAW_W-1:0] next_prev_raw;
	logic [RAW_W-1:0] next_filt;
	logic             next_bypass;
	logic             next_primed;
	logic [RAW_W-1:0] diff;
	logic [36:0]      step_scaled;
	logic             big_step;
	logic [31:0]      blend;

	always_comb begin
		diff        = (raw_i >= prev_raw) ? raw_i - prev_raw : prev_raw - raw_i;
		step_scaled = 37'(diff) * 37'(STEP_DIV);
		big_step    = step_scaled > 37'(fscale_i);
		blend       = (32'(filt_o) * 32'(weight_i)
			+ 32'(raw_i) * 32'(PCT_FULL - weight_i)) / 32'(PCT_FULL);
		next_prev_raw = prev_raw;
		next_filt     = filt_o;
		next_bypass   = bypass_o;
		next_primed   = primed_o;
		if (sample_stb_i) begin
			next_prev_raw = raw_i;
			next_primed   = 1'b1;
			// History survives range switches; only reset clears it.
			if (!primed_o) begin
				next_filt   = raw_i;
				next_bypass = 1'b0;
			end else if (weight_i == 7'h00) begin
				next_filt   = raw_i;
				next_bypass = 1'b0;
			end else if (big_step) begin
				// Large steps pass through, bounding any skew.
				next_filt   = raw_i;
				next_bypass = 1'b1;
			end else begin
				next_filt   = blend[RAW_W-1:0];
				next_bypass = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			prev_raw <= '0;
			filt_o   <= '0;
			bypass_o <= 1'b0;
			primed_o <= 1'b0;
		end else begin
			prev_raw <= next_prev_raw;
			filt_o   <= next_filt;
			bypass_o <= next_bypass;
			primed_o <= next_primed;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	chk_first_sample: assert property (
		sample_stb_i && !primed_o |=> primed_o && filt_o == $past(raw_i))
		else $error("first sample not loaded into history");

	chk_step_bypass: assert property (
		sample_stb_i && primed_o && weight_i != 7'h00
			&& 37'(diff) * 37'(STEP_DIV) > 37'(fscale_i)
		|=> bypass_o && filt_o == $past(raw_i))
		else $error("large step was smoothed");

	chk_smooth_math: assert property (
		sample_stb_i && primed_o && weight_i != 7'h00 && !big_step
		|=> !bypass_o && 32'(filt_o) == (32'($past(filt_o)) * 32'($past(weight_i))
			+ 32'($past(raw_i)) * 32'(PCT_FULL - $past(weight_i))) / 32'(PCT_FULL))
		else $error("smoothed value does not match weighted blend");

	chk_zero_weight: assert property (
		sample_stb_i && weight_i == 7'h00 |=> filt_o == $past(raw_i))
		else $error("zero weight did not pass raw sample");

	chk_hold_between: assert property (
		!sample_stb_i |=> $stable(filt_o) && $stable(primed_o))
		else $error("filter history changed without a sample");

endmodule

// File: rtl/sft_core.sv
// Core of a sampling pressure transducer: sample timer, per-range filter settings,
// serial frame receiver and address filter, AXI4-Lite register slave.
// Assumes raw samples and the serial receive line are synchronous to clk_i.
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module sft_core #(
	parameter int unsigned SAMPLE_CYC_P = sft_pkg::SAMPLE_CYC
) (
	// Clock and reset
	input  wire logic                      clk_i,
	input  wire logic                      sys_rst_i,
	// AXI4-Lite write channels
	input  wire logic [7:0]                s_axi_awaddr_i,
	input  wire logic                      s_axi_awvalid_i,
	output logic                           s_axi_awready_o,
	input  wire logic [31:0]               s_axi_wdata_i,
	input  wire logic [3:0]                s_axi_wstrb_i,
	input  wire logic                      s_axi_wvalid_i,
	output logic                           s_axi_wready_o,
	output logic      [1:0]                s_axi_bresp_o,
	output logic                           s_axi_bvalid_o,
	input  wire logic                      s_axi_bready_i,
	// AXI4-Lite read channels
	input  wire logic [7:0]                s_axi_araddr_i,
	input  wire logic                      s_axi_arvalid_i,
	output logic                           s_axi_arready_o,
	output logic      [31:0]               s_axi_rdata_o,
	output logic      [1:0]                s_axi_rresp_o,
	output logic                           s_axi_rvalid_o,
	input  wire logic                      s_axi_rready_i,
	// Pressure front end
	input  wire logic [sft_pkg::RAW_W-1:0] raw_sample_i,
	output logic                           sample_stb_o,
	output logic      [sft_pkg::RAW_W-1:0] pressure_o,
	output logic                           pressure_valid_o,
	// Serial receive and decoded frames
	input  wire logic                      rx_i,
	output sft_pkg::sft_frame_t            cmd_o,
	output logic                           cmd_valid_o,
	output logic      [7:0]                reply_lead_o
);
	import sft_pkg::*;

	function automatic logic [7:0] to_upper(input logic [7:0] c);
		return (c >= 8'h61 && c <= 8'h7A) ? c - 8'h20 : c;
	endfunction

	function automatic logic addr_ok(input logic [7:0] c);
		return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h5A);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// ------------------------------------------------------------
	// Sample timer
	// ------------------------------------------------------------
	logic [31:0]      tick_cnt;
	logic [31:0]      next_tick_cnt;
	logic             next_sample_stb;
	logic [RAW_W-1:0] raw_hold;
	logic [RAW_W-1:0] next_raw_hold;

	always_comb begin
		next_sample_stb = 1'b0;
		next_tick_cnt   = tick_cnt + 32'h1;
		next_raw_hold   = raw_hold;
		if (tick_cnt == 32'(SAMPLE_CYC_P - 1)) begin
			next_tick_cnt   = 32'h0;
			next_sample_stb = 1'b1;
			next_raw_hold   = raw_sample_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			tick_cnt         <= 32'h0;
			sample_stb_o     <= 1'b0;
			raw_hold         <= '0;
			pressure_valid_o <= 1'b0;
		end else begin
			tick_cnt         <= next_tick_cnt;
			sample_stb_o     <= next_sample_stb;
			raw_hold         <= next_raw_hold;
			pressure_valid_o <= sample_stb_o;
		end
	end

	// ------------------------------------------------------------
	// Registers and AXI4-Lite slave
	// ------------------------------------------------------------
	sft_range_cfg_t cfg [2];
	sft_range_cfg_t next_cfg [2];
	logic           range_sel;
	logic           next_range_sel;
	logic [15:0]    baud_div;
	logic [15:0]    next_baud_div;
	logic           aw_full, w_full;
	logic           next_aw_full, next_w_full;
	logic [7:0]     wa, next_wa;
	logic [31:0]    wd, next_wd;
	logic [3:0]     ws, next_ws;
	logic           next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
	logic [1:0]     next_bresp, next_rresp;
	logic [31:0]    next_rdata;
	logic [31:0]    wv;
	logic [7:0]     up;
	logic           filt_bypass, filt_primed;
	sft_range_cfg_t act;

	assign act = cfg[range_sel];

	always_comb begin
		next_cfg       = cfg;
		next_range_sel = range_sel;
		next_baud_div  = baud_div;
		next_aw_full   = aw_full;
		next_w_full    = w_full;
		next_wa        = wa;
		next_wd        = wd;
		next_ws        = ws;
		next_bvalid    = s_axi_bvalid_o;
		next_bresp     = s_axi_bresp_o;
		next_rvalid    = s_axi_rvalid_o;
		next_rresp     = s_axi_rresp_o;
		next_rdata     = s_axi_rdata_o;
		wv             = 32'h0;
		up             = 8'h00;
		if (s_axi_bvalid_o && s_axi_bready_i) begin
			next_bvalid = 1'b0;
		end
		if (s_axi_awvalid_i && s_axi_awready_o) begin
			next_aw_full = 1'b1;
			next_wa      = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && s_axi_wready_o) begin
			next_w_full = 1'b1;
			next_wd     = s_axi_wdata_i;
			next_ws     = s_axi_wstrb_i;
		end
		if (next_aw_full && next_w_full && !next_bvalid) begin
			next_aw_full = 1'b0;
			next_w_full  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = RESP_OKAY;
			unique case ({next_wa[7:2], 2'b00})
				OFS_CTRL: begin
					wv             = merge({31'h0, range_sel}, next_wd, next_ws);
					next_range_sel = wv[0];
				end
				OFS_WEIGHT0, OFS_WEIGHT1: begin
					wv = merge({25'h0, cfg[next_wa[3]].weight}, next_wd, next_ws);
					// Out-of-range weights saturate instead of wrapping.
					next_cfg[next_wa[3]].weight = (wv > 32'(WEIGHT_MAX)) ? WEIGHT_MAX
						: wv[6:0];
				end
				OFS_ADDR0, OFS_ADDR1: begin
					wv = merge({24'h0, cfg[next_wa[4]].addr}, next_wd, next_ws);
					up = to_upper(wv[7:0]);
					// Invalid address characters are dropped, keeping the old one.
					if (wv[31:8] == 24'h0 && addr_ok(up)) begin
						next_cfg[next_wa[4]].addr = up;
					end
				end
				OFS_FSCALE0, OFS_FSCALE1: begin
					wv = merge({8'h0, cfg[next_wa[3]].fscale}, next_wd, next_ws);
					next_cfg[next_wa[3]].fscale = wv[23:0];
				end
				OFS_BAUD: begin
					wv            = merge({16'h0, baud_div}, next_wd, next_ws);
					next_baud_div = (wv[15:0] < 16'h0004) ? 16'h0004 : wv[15:0];
				end
				default: next_bresp = RESP_SLVERR;
			endcase
		end
		if (s_axi_rvalid_o && s_axi_rready_i) begin
			next_rvalid = 1'b0;
		end
		if (s_axi_arvalid_i && s_axi_arready_o) begin
			next_rvalid = 1'b1;
			next_rresp  = RESP_OKAY;
			unique case ({s_axi_araddr_i[7:2], 2'b00})
				OFS_CTRL:    next_rdata = {31'h0, range_sel};
				OFS_WEIGHT0: next_rdata = {25'h0, cfg[0].weight};
				OFS_WEIGHT1: next_rdata = {25'h0, cfg[1].weight};
				OFS_ADDR0:   next_rdata = {24'h0, cfg[0].addr};
				OFS_ADDR1:   next_rdata = {24'h0, cfg[1].addr};
				OFS_FSCALE0: next_rdata = {8'h0, cfg[0].fscale};
				OFS_FSCALE1: next_rdata = {8'h0, cfg[1].fscale};
				OFS_BAUD:    next_rdata = {16'h0, baud_div};
				OFS_PRESS:   next_rdata = {8'h0, pressure_o};
				OFS_RAW:     next_rdata = {8'h0, raw_hold};
				OFS_STATUS:  next_rdata = {30'h0, filt_primed, filt_bypass};
				default: begin
					next_rdata = 32'h0;
					next_rresp = RESP_SLVERR;
				end
			endcase
		end
		next_awready = !next_aw_full && !next_bvalid;
		next_wready  = !next_w_full && !next_bvalid;
		next_arready = !next_rvalid;
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < 2; i++) begin
				cfg[i] <= '{addr: ADDR_RST,
					weight: WEIGHT_RST, fscale: FSCALE_RST};
			end
			range_sel       <= 1'b0;
			baud_div        <= BAUD_DIV_RST;
			aw_full         <= 1'b0;
			w_full          <= 1'b0;
			wa              <= 8'h00;
			wd              <= 32'h0;
			ws              <= 4'h0;
			s_axi_awready_o <= 1'b0;
			s_axi_wready_o  <= 1'b0;
			s_axi_bvalid_o  <= 1'b0;
			s_axi_bresp_o   <= RESP_OKAY;
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rresp_o   <= RESP_OKAY;
			s_axi_rdata_o   <= 32'h0;
			reply_lead_o    <= ADDR_RST;
		end else begin
			cfg             <= next_cfg;
			range_sel       <= next_range_sel;
			baud_div        <= next_baud_div;
			aw_full         <= next_aw_full;
			w_full          <= next_w_full;
			wa              <= next_wa;
			wd              <= next_wd;
			ws              <= next_ws;
			s_axi_awready_o <= next_awready;
			s_axi_wready_o  <= next_wready;
			s_axi_bvalid_o  <= next_bvalid;
			s_axi_bresp_o   <= next_bresp;
			s_axi_arready_o <= next_arready;
			s_axi_rvalid_o  <= next_rvalid;
			s_axi_rresp_o   <= next_rresp;
			s_axi_rdata_o   <= next_rdata;
			reply_lead_o    <= act.addr;
		end
	end

	// ------------------------------------------------------------
	// Filter
	// ------------------------------------------------------------
	sft_filter u_filter (
		.clk_i        (clk_i),
		.sys_rst_i    (sys_rst_i),
		.sample_stb_i (sample_stb_o),
		.raw_i        (raw_hold),
		.weight_i     (act.weight),
		.fscale_i     (act.fscale),
		.filt_o       (pressure_o),
		.bypass_o     (filt_bypass),
		.primed_o     (filt_primed)
	);

	// ------------------------------------------------------------
	// Serial receiver, 8 data bits, no parity, 1 stop bit
	// ------------------------------------------------------------
	sft_rx_t     rx_st, next_rx_st;
	logic [15:0] rx_cnt, next_rx_cnt;
	logic [2:0]  rx_bit, next_rx_bit;
	logic [7:0]  rx_sh, next_rx_sh;
	logic        byte_stb, next_byte_stb;

	always_comb begin
		next_rx_st    = rx_st;
		next_rx_cnt   = (rx_cnt == 16'h0) ? 16'h0 : rx_cnt - 16'h1;
		next_rx_bit   = rx_bit;
		next_rx_sh    = rx_sh;
		next_byte_stb = 1'b0;
		unique case (rx_st)
			RX_IDLE: if (!rx_i) begin
				next_rx_st  = RX_START;
				next_rx_cnt = {1'b0, baud_div[15:1]};
			end
			RX_START: if (rx_cnt == 16'h0) begin
				next_rx_st  = rx_i ? RX_IDLE : RX_DATA;
				next_rx_cnt = baud_div - 16'h1;
				next_rx_bit = 3'h0;
			end
			RX_DATA: if (rx_cnt == 16'h0) begin
				next_rx_sh  = {rx_i, rx_sh[7:1]};
				next_rx_cnt = baud_div - 16'h1;
				next_rx_bit = rx_bit + 3'h1;
				if (rx_bit == 3'h7) begin
					next_rx_st = RX_STOP;
				end
			end
			RX_STOP: if (rx_cnt == 16'h0) begin
				// A missing stop bit discards the character as a framing error.
				next_byte_stb = rx_i;
				next_rx_st    = RX_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rx_st    <= RX_IDLE;
			rx_cnt   <= 16'h0;
			rx_bit   <= 3'h0;
			rx_sh    <= 8'h00;
			byte_stb <= 1'b0;
		end else begin
			rx_st    <= next_rx_st;
			rx_cnt   <= next_rx_cnt;
			rx_bit   <= next_rx_bit;
			rx_sh    <= next_rx_sh;
			byte_stb <= next_byte_stb;
		end
	end

	// ------------------------------------------------------------
	// Frame parser and address filter
	// ------------------------------------------------------------
	sft_parse_t ps, next_ps;
	logic       have_cmd, next_have_cmd;
	sft_frame_t next_cmd;
	logic       next_cmd_valid;
	logic [7:0] ch;

	always_comb begin
		ch             = to_upper(rx_sh);
		next_ps        = ps;
		next_have_cmd  = have_cmd;
		next_cmd       = cmd_o;
		next_cmd_valid = 1'b0;
		if (byte_stb) begin
			if (ch == CH_START) begin
				// A pound always restarts, so a broken frame cannot swallow the next.
				next_ps       = PS_ADDR;
				next_have_cmd = 1'b0;
			end else begin
				unique case (ps)
					PS_IDLE: next_ps = PS_IDLE;
					PS_ADDR: begin
						// Only the active range address or the wildcard is accepted.
						next_ps = (ch == act.addr || ch == CH_WILD) ? PS_BODY
							: PS_SKIP;
					end
					PS_BODY: begin
						if (ch == CH_CR || ch == CH_LF) begin
							next_ps        = PS_IDLE;
							next_cmd_valid = have_cmd;
						end else if (!have_cmd) begin
							next_have_cmd = 1'b1;
							next_cmd      = '{cmd: ch, query: ch == CH_QUERY};
						end
					end
					PS_SKIP: if (ch == CH_CR || ch == CH_LF) begin
						next_ps = PS_IDLE;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ps          <= PS_IDLE;
			have_cmd    <= 1'b0;
			cmd_o       <= '{cmd: 8'h00, query: 1'b0};
			cmd_valid_o <= 1'b0;
		end else begin
			ps          <= next_ps;
			have_cmd    <= next_have_cmd;
			cmd_o       <= next_cmd;
			cmd_valid_o <= next_cmd_valid;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	logic [31:0] gap;
	logic        seen;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			gap  <= 32'h0;
			seen <= 1'b0;
		end else begin
			gap  <= sample_stb_o ? 32'h0 : gap + 32'h1;
			seen <= seen | sample_stb_o;
		end
	end

	sequence s_frame_open;
		byte_stb && ch == CH_START;
	endsequence
	sequence s_foreign_addr;
		byte_stb && ch != act.addr && ch != CH_WILD && ch != CH_START;
	endsequence

	chk_sample_period: assert property (
		sample_stb_o && seen |-> gap == 32'(SAMPLE_CYC_P - 1))
		else $error("sample strobe spacing wrong");
	chk_weight_range: assert property (
		cfg[0].weight <= WEIGHT_MAX && cfg[1].weight <= WEIGHT_MAX)
		else $error("filter weight above limit");
	chk_reset_values: assert property (
		$past(sys_rst_i) |-> cfg[0].weight == WEIGHT_RST && cfg[1].addr == ADDR_RST)
		else $error("reset defaults wrong");
	chk_addr_legal: assert property (
		addr_ok(cfg[0].addr) && addr_ok(cfg[1].addr))
		else $error("stored address not a legal character");
	chk_foreign_skip: assert property (
		ps == PS_ADDR ##0 s_foreign_addr |=> ps == PS_SKIP)
		else $error("frame for another address not skipped");
	chk_frame_restart: assert property (
		s_frame_open |=> ps == PS_ADDR)
		else $error("pound did not restart the frame");
	chk_skip_silent: assert property (
		ps == PS_SKIP |=> !cmd_valid_o)
		else $error("command issued for unmatched frame");
	chk_reply_lead: assert property (
		##1 reply_lead_o == $past(act.addr))
		else $error("reply lead not active address");
	chk_wild_accept: assert property (
		ps == PS_ADDR && byte_stb && ch == CH_WILD |=> ps == PS_BODY)
		else $error("wildcard address rejected");

endmodule

// File: verif/sft_host_model.sv
// Host serial driver model: sends 8N1 bytes, LSB first, on the receive line.
// Assumes the device baud divisor has been set to DIV.
`timescale 1ns/1ps
module sft_host_model #(
	parameter int DIV = 8
) (
	// Clock
	input  wire logic clk_i,
	// Serial line, idle high
	output logic      rx_o
);
	initial rx_o = 1'b1;
	// Only one device hangs on this link, so addresses never collide.
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk_i);
			rx_o <= f[i];
			repeat (DIV - 1) @(posedge clk_i);
		end
	endtask
endmodule

// File: verif/sft_core_tb.sv
// Self-checking bench for the sample filter and range addressing core.
// Assumes a short sample period parameter and a host model on the receive line.
`timescale 1ns/1ps
module sft_core_tb;
	import sft_pkg::*;
	localparam int DIV = 8;
	logic        clk_i = 0, sys_rst_i = 1, rx_i;
	logic [7:0]  s_axi_awaddr_i = 0, s_axi_araddr_i = 0, reply_lead_o;
	logic [31:0] s_axi_wdata_i = 0, s_axi_rdata_o;
	logic [3:0]  s_axi_wstrb_i = 4'hF;
	logic        s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
	logic        s_axi_arvalid_i = 0, s_axi_rready_i = 0;
	logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
	logic        s_axi_rvalid_o, sample_stb_o, pressure_valid_o, cmd_valid_o;
	logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
	logic [23:0] raw_sample_i = 24'h0F4240, pressure_o;
	sft_frame_t  cmd_o;
	int          num_errors = 0, n_checks = 0, n_cmd = 0;
	sft_core #(.SAMPLE_CYC_P(50)) dut (.clk_i, .sys_rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
		.s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
		.s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
		.s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
		.raw_sample_i, .sample_stb_o, .pressure_o, .pressure_valid_o, .rx_i, .cmd_o,
		.cmd_valid_o, .reply_lead_o);
	sft_host_model #(.DIV(DIV)) host (.clk_i, .rx_o(rx_i));
	initial forever #25 clk_i = ~clk_i;
	always @(posedge clk_i) if (cmd_valid_o === 1'b1) n_cmd <= n_cmd + 1;
	// ------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge clk_i);
		s_axi_awaddr_i  <= a;
		s_axi_wdata_i   <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i  <= 1'b1;
		s_axi_bready_i  <= 1'b1;
		do begin
			@(posedge clk_i);
			if (s_axi_awready_o === 1'b1) s_axi_awvalid_i <= 1'b0;
			if (s_axi_wready_o === 1'b1) s_axi_wvalid_i <= 1'b0;
		end while (s_axi_bvalid_o !== 1'b1);
		s_axi_bready_i <= 1'b0;
		chk(32'(s_axi_bresp_o), 32'(r));
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		@(posedge clk_i);
		s_axi_araddr_i  <= a;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i  <= 1'b1;
		do begin
			@(posedge clk_i);
			if (s_axi_arready_o === 1'b1) s_axi_arvalid_i <= 1'b0;
		end while (s_axi_rvalid_o !== 1'b1);
		s_axi_rready_i <= 1'b0;
		chk(s_axi_rdata_o, e);
		chk(32'(s_axi_rresp_o), 32'(r));
	endtask
	task automatic smp(input logic [23:0] raw, input logic [23:0] e);
		raw_sample_i <= raw;
		do @(posedge clk_i); while (pressure_valid_o !== 1'b1);
		chk(32'(pressure_o), 32'(e));
		chk(32'(sample_stb_o), 32'h0);
	endtask
	task automatic frame(input logic [7:0] a, input int e);
		int c0;
		c0 = n_cmd;
		host.send(CH_START);
		host.send(a);
		host.send(CH_QUERY);
		host.send(CH_CR);
		repeat (40) @(posedge clk_i);
		chk(32'(n_cmd - c0), 32'(e));
	endtask
	task automatic end_of_test;
		$display("Checks %0d, errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		repeat (4) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		rd(OFS_WEIGHT0, 32'h5A, RESP_OKAY);
		rd(OFS_ADDR1, 32'h31, RESP_OKAY);
		rd(OFS_BAUD, 32'h823, RESP_OKAY);
		rd(8'h3C, 32'h0, RESP_SLVERR);
		wr(OFS_PRESS, 32'h0, RESP_SLVERR);
		smp(24'h0F4240, 24'h0F4240);
		smp(24'h0F42A4, 24'h0F424A);
		smp(24'h0F9060, 24'h0F9060);
		wr(OFS_WEIGHT0, 32'h96, RESP_OKAY);
		rd(OFS_WEIGHT0, 32'h63, RESP_OKAY);
		wr(OFS_WEIGHT0, 32'h0, RESP_OKAY);
		smp(24'h0F9092, 24'h0F9092);
		wr(OFS_WEIGHT1, 32'h32, RESP_OKAY);
		wr(OFS_ADDR1, 32'h62, RESP_OKAY);
		rd(OFS_ADDR1, 32'h42, RESP_OKAY);
		wr(OFS_CTRL, 32'h1, RESP_OKAY);
		smp(24'h0F909C, 24'h0F9097);
		rd(OFS_ADDR0, 32'h31, RESP_OKAY);
		wr(OFS_BAUD, 32'(DIV), RESP_OKAY);
		frame(8'h31, 0);
		frame(8'h62, 1);
		chk(32'(cmd_o), {23'h0, CH_QUERY, 1'b1});
		frame(8'h2A, 1);
		chk(32'(reply_lead_o), 32'h42);
		frame(8'h5A, 0);
		// Start right after a sample so the next tick sees the new raw value.
		do @(posedge clk_i); while (pressure_valid_o !== 1'b1);
		wr(OFS_WEIGHT1, 32'h0, RESP_OKAY);
		smp(24'h0F90A6, 24'h0F90A6);
		end_of_test();
	end
	// A hang anywhere above ends the run here as a failure.
	initial begin
		repeat (20000) @(posedge clk_i);
		num_errors++;
		$display("ERROR %0t: timeout", $time);
		end_of_test();
	end
endmodule
